// ### scp_readout.sv
// read-out and cascade logic of a serial configuration memory
// assumes all memory pins arrive asynchronously and are sampled here
// Notes on behaviour
// - after the last bit the next link edge drops chain enable, frees data.
// - a low chip select from an upstream chain enable lets data out.
// - an active clear resets the address counters of each chained memory.
// - a low program select enters programming mode and stops read-out.
// - programming mode loads contents from the data pin, not the read path.
// - the active level of the clear input follows a stored polarity bit.
// - a high chip select outside programming mode puts the memory into standby.
// - in standby the data pin floats whatever the output enable says.
// - each link edge advances the counters in read-out while chip select is low until the last bit, and in programming unless the clear pin is high.
// - an active clear resets both the address and the bit counter.
// - data drives only while chip select and output enable both allow it.
// - chain enable stays high until the last bit, then tracks chip select until a clear.
`timescale 1ns/1ns
module scp_readout #(
  parameter int unsigned MEM_BITS = scp_pkg::MEM_BITS_DEF
) (
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  input  wire logic i_array_config_clock,
  input  wire logic i_chip_select_n,
  input  wire logic i_clear_oe,
  input  wire logic i_serial_program_select,
  input  wire logic i_data,
  output logic      o_data,
  output logic      o_data_oe,
  output logic      o_chain_enable_out_n,
  output logic      o_standby,
  output logic      o_clear_polarity_high
);
  localparam int unsigned AW = $clog2(MEM_BITS);
  localparam logic [AW-1:0] LAST_ADDR = AW'(MEM_BITS - 1);
  localparam int unsigned BW = scp_pkg::BUF_WIDTH_DEF;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [scp_pkg::PIN_COUNT-1:0] meta_reg;
  logic [scp_pkg::PIN_COUNT-1:0] pin_reg;
  logic                          clk_prev_reg;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_reg <= scp_pkg::PIN_RESET_VAL;
      pin_reg  <= scp_pkg::PIN_RESET_VAL;
    end else begin
      meta_reg <= {i_data, i_serial_program_select, i_clear_oe,
                   i_chip_select_n, i_array_config_clock};
      pin_reg  <= meta_reg;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      clk_prev_reg <= 1'h0;
    end else begin
      clk_prev_reg <= pin_reg[scp_pkg::PIN_LINK_CLK];
    end
  end

  logic link_edge;
  logic cs_n;
  logic clear_pin;
  logic prog_mode;
  logic pol_high_reg;
  logic clear_act;
  logic oe_act;
  logic standby;
  assign link_edge = pin_reg[scp_pkg::PIN_LINK_CLK] && !clk_prev_reg;
  assign cs_n      = pin_reg[scp_pkg::PIN_CHIP_SEL];
  assign clear_pin = pin_reg[scp_pkg::PIN_CLEAR_OE];
  assign prog_mode = !pin_reg[scp_pkg::PIN_PROG_SEL];
  assign clear_act = !prog_mode && (clear_pin == pol_high_reg);
  assign oe_act    = !clear_act;
  assign standby   = !prog_mode && cs_n;

  // ----------------------------------------------------------------------
  // storage and programming
  // ----------------------------------------------------------------------
  // polarity bit is written in programming mode on an edge with the
  // clear pin high; other programming edges write one data bit each
  logic          mem [0:MEM_BITS-1];
  logic [AW-1:0] prog_addr_reg;
  logic          prog_wr;
  logic          pol_wr;
  assign prog_wr = prog_mode && link_edge && !clear_pin;
  assign pol_wr  = prog_mode && link_edge && clear_pin;

  always_ff @(posedge i_clock) begin
    if (prog_wr) begin
      mem[prog_addr_reg] <= pin_reg[scp_pkg::PIN_DATA_IN];
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prog_addr_reg <= '0;
    end else if (!prog_mode) begin
      prog_addr_reg <= '0;
    end else if (prog_wr) begin
      prog_addr_reg <= prog_addr_reg + AW'(1);
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pol_high_reg <= scp_pkg::POLARITY_RESET;
    end else if (pol_wr) begin
      pol_high_reg <= pin_reg[scp_pkg::PIN_DATA_IN];
    end
  end

  // ----------------------------------------------------------------------
  // prefetch into the two-entry buffer
  // ----------------------------------------------------------------------
  // fetching runs far ahead of the slow link clock, so the buffer hides
  // the read latency; a full buffer simply stalls the fetch counter
  logic [AW-1:0] fetch_addr_reg;
  logic          fetch_done_reg;
  logic          flush;
  logic          buf_in_ready;
  logic          buf_out_valid;
  logic          buf_pop;
  logic [BW-1:0] buf_out_data;
  logic          fetch_push;
  assign flush      = clear_act || prog_mode;
  assign fetch_push = !flush && !fetch_done_reg && buf_in_ready;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fetch_addr_reg <= '0;
      fetch_done_reg <= 1'h0;
    end else if (flush) begin
      fetch_addr_reg <= '0;
      fetch_done_reg <= 1'h0;
    end else if (fetch_push) begin
      fetch_addr_reg <= fetch_addr_reg + AW'(1);
      fetch_done_reg <= (fetch_addr_reg == LAST_ADDR);
    end
  end

  scp_buf2 #(
    .WIDTH (BW)
  ) u_buf (
    .i_clock     (i_clock),
    .i_arst_n    (i_arst_n),
    .i_flush     (flush),
    .i_in_valid  (fetch_push),
    .o_in_ready  (buf_in_ready),
    .i_in_data   (mem[fetch_addr_reg]),
    .o_out_valid (buf_out_valid),
    .i_out_ready (buf_pop),
    .o_out_data  (buf_out_data)
  );

  // ----------------------------------------------------------------------
  // read-out counter and output stage
  // ----------------------------------------------------------------------
  logic [AW-1:0] bit_addr_reg;
  logic          cur_valid_reg;
  logic          done_reg;
  logic          shift;
  assign shift   = link_edge && !flush && !standby && !done_reg
                   && cur_valid_reg;
  assign buf_pop = buf_out_valid && !flush
                   && (!cur_valid_reg || (shift && bit_addr_reg != LAST_ADDR));

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_addr_reg  <= '0;
      cur_valid_reg <= 1'h0;
      done_reg      <= 1'h0;
    end else if (flush) begin
      bit_addr_reg  <= '0;
      cur_valid_reg <= 1'h0;
      done_reg      <= 1'h0;
    end else if (shift) begin
      if (bit_addr_reg == LAST_ADDR) begin
        done_reg      <= 1'h1;
        cur_valid_reg <= 1'h0;
      end else begin
        bit_addr_reg  <= bit_addr_reg + AW'(1);
        cur_valid_reg <= buf_out_valid;
      end
    end else if (buf_pop) begin
      cur_valid_reg <= 1'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data <= scp_pkg::DATA_RESET;
    end else if (buf_pop) begin
      o_data <= buf_out_data[0];
    end
  end

  // enable waits for the first bit so the pin never shows a stale value
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data_oe <= 1'h0;
    end else begin
      o_data_oe <= !prog_mode && !cs_n && oe_act && !done_reg
                   && (cur_valid_reg || buf_pop) && !(shift
                   && bit_addr_reg == LAST_ADDR);
    end
  end

  // chain enable: low after the last bit while selected, then follows
  // chip select until the clear input ends the pass
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_chain_enable_out_n <= scp_pkg::CHAIN_RESET;
    end else if (flush) begin
      o_chain_enable_out_n <= 1'h1;
    end else if (done_reg || (shift && bit_addr_reg == LAST_ADDR)) begin
      o_chain_enable_out_n <= cs_n;
    end else begin
      o_chain_enable_out_n <= 1'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_standby             <= 1'h0;
      o_clear_polarity_high <= scp_pkg::POLARITY_RESET;
    end else begin
      o_standby             <= standby;
      o_clear_polarity_high <= pol_high_reg;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);

  AST_LAST_BIT_RELEASE: assert property (
    shift && bit_addr_reg == LAST_ADDR |=> !o_data_oe && done_reg)
    else $error("data still driven after last bit");
  AST_CHAIN_LOW: assert property (
    shift && bit_addr_reg == LAST_ADDR && !cs_n |=> !o_chain_enable_out_n)
    else $error("chain enable not low after last bit");
  AST_CLEAR_RESETS: assert property (
    clear_act |=> bit_addr_reg == '0 && !done_reg && !cur_valid_reg)
    else $error("clear did not reset counters");
  AST_CLEAR_CHAIN: assert property (
    clear_act |=> o_chain_enable_out_n)
    else $error("chain enable low during clear");
  AST_PROG_NO_DRIVE: assert property (
    prog_mode |=> !o_data_oe)
    else $error("data driven in programming mode");
  AST_STANDBY_FLOAT: assert property (
    standby |=> !o_data_oe && o_standby)
    else $error("data driven in standby");
  AST_OE_NEEDS_BOTH: assert property (
    o_data_oe |-> !$past(cs_n) && $past(oe_act))
    else $error("data driven without both enables");
  AST_ADVANCE: assert property (
    shift && bit_addr_reg != LAST_ADDR
    |=> bit_addr_reg == $past(bit_addr_reg) + AW'(1))
    else $error("counter did not advance");
  AST_PROG_ADVANCE: assert property (
    prog_wr |=> prog_mode |-> prog_addr_reg == $past(prog_addr_reg) + AW'(1))
    else $error("programming counter did not advance");
  AST_POLARITY: assert property (
    pol_wr |=> pol_high_reg == $past(pin_reg[scp_pkg::PIN_DATA_IN]))
    else $error("polarity bit not stored");

  COV_FIRST_SHIFT: cover property (shift && bit_addr_reg == '0);
  COV_LAST_SHIFT:  cover property (shift && bit_addr_reg == LAST_ADDR);
  COV_BUF_FULL:    cover property (!buf_in_ready && !flush);
  COV_PROG_WRITE:  cover property (prog_wr);
endmodule

// ### scp_pkg.sv
// constants shared by the serial configuration memory read-out block
// assumes a single system clock that samples every memory pin
package scp_pkg;
  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  localparam int unsigned MEM_BITS_DEF   = 262144;
  localparam int unsigned BUF_WIDTH_DEF  = 1;
  // ----------------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------------
  localparam int unsigned PIN_COUNT      = 5;
  localparam int unsigned PIN_LINK_CLK   = 0;
  localparam int unsigned PIN_CHIP_SEL   = 1;
  localparam int unsigned PIN_CLEAR_OE   = 2;
  localparam int unsigned PIN_PROG_SEL   = 3;
  localparam int unsigned PIN_DATA_IN    = 4;
  // link clock idles low, so its reset value must not fake a rising edge
  localparam logic [4:0]  PIN_RESET_VAL  = 5'h0e;
  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic        POLARITY_RESET = 1'h1;  // high level clears
  localparam logic        CHAIN_RESET    = 1'h1;
  localparam logic        DATA_RESET     = 1'h0;
endpackage

// ### scp_buf2.sv
// two-entry valid/ready buffer with a synchronous flush
// assumes both sides run on the same clock
`timescale 1ns/1ns
module scp_buf2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_arst_n,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  logic [WIDTH-1:0] slot_reg [0:1];
  logic [1:0]       count_reg;
  logic             rd_ptr_reg;
  logic             wr_ptr_reg;
  logic             push;
  logic             pop;

  assign o_in_ready  = (count_reg != 2'h2);
  assign o_out_valid = (count_reg != 2'h0);
  assign o_out_data  = slot_reg[rd_ptr_reg];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      count_reg  <= 2'h0;
      rd_ptr_reg <= 1'h0;
      wr_ptr_reg <= 1'h0;
    end else if (i_flush) begin
      count_reg  <= 2'h0;
      rd_ptr_reg <= 1'h0;
      wr_ptr_reg <= 1'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 2'h1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 2'h1;
      end
    end
  end

  // data slots carry no reset: only valid entries are ever read
  always_ff @(posedge i_clock) begin
    if (push) begin
      slot_reg[wr_ptr_reg] <= i_in_data;
    end
  end
endmodule

// ### scp_gate_model.sv
// gate array model in master serial mode: makes the link clock and pins
// assumes callers run just after a system clock edge, at a fixed offset
`timescale 1ns/1ns
module scp_gate_model (
  input  wire logic i_clock,
  input  wire logic i_mem_data,
  input  wire logic i_mem_data_oe,
  output logic      o_link_clock,
  output logic      o_chip_select_n,
  output logic      o_clear_oe,
  output logic      o_program_select,
  output logic      o_data_wire
);
  logic drv_en;
  logic drv_val;
  logic float_q = 1'h0;
  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  initial begin
    o_link_clock     = 1'h0;
    o_chip_select_n  = 1'h1;
    o_clear_oe       = 1'h1;
    o_program_select = 1'h1;
    drv_en           = 1'h0;
    drv_val          = 1'h0;
  end
  // a released line changes every cycle, so a stale bit cannot pass
  always @(posedge i_clock) float_q <= ~float_q;
  assign o_data_wire = i_mem_data_oe ? i_mem_data :
                       (drv_en ? drv_val : float_q);
  task automatic set_pins(input logic cs_n, input logic clr,
                          input logic prog);
    o_chip_select_n  = cs_n;
    o_clear_oe       = clr;
    o_program_select = prog;
  endtask
  task automatic set_data(input logic en, input logic val);
    drv_en  = en;
    drv_val = val;
  endtask
  // ----------------------------------------------------------------------
  // link clock
  // ----------------------------------------------------------------------
  // one 400 ns period, standing low between pulses; the array takes data
  task automatic pulse();
    o_link_clock = 1'h1;
    repeat (4) @(posedge i_clock);
    #2;
    o_link_clock = 1'h0;
    repeat (4) @(posedge i_clock);
    #2;
  endtask
endmodule

// ### scp_readout_tb_top.sv
// self-checking bench for the serial configuration memory read-out
// assumes the gate array model drives every memory pin
`timescale 1ns/1ns
module scp_readout_tb_top;
  localparam logic [15:0] PAT = 16'hc3a5;
  localparam int CYC_MAX = 5000;
  // rows: chip select, clear, program select | standby, data enable
  localparam logic [4:0] ROWS [6] = '{5'h05, 5'h0c, 5'h16, 5'h1e,
                                     5'h10, 5'h05};
  logic i_clock;
  logic i_arst_n;
  logic link_clock;
  logic chip_select_n;
  logic clear_oe;
  logic program_select;
  logic data_wire;
  logic mem_data;
  logic mem_data_oe;
  logic chain_enable_out_n;
  logic standby;
  logic clear_polarity_high;
  int   num_errors = 0;
  int   cmp_count = 0;
  int   cyc = 0;
  scp_readout #(.MEM_BITS(16)) dut_u (
    .i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_array_config_clock(link_clock), .i_chip_select_n(chip_select_n),
    .i_clear_oe(clear_oe), .i_serial_program_select(program_select),
    .i_data(data_wire), .o_data(mem_data), .o_data_oe(mem_data_oe),
    .o_chain_enable_out_n(chain_enable_out_n), .o_standby(standby),
    .o_clear_polarity_high(clear_polarity_high)
  );
  scp_gate_model gm_u (
    .i_clock(i_clock), .i_mem_data(mem_data),
    .i_mem_data_oe(mem_data_oe), .o_link_clock(link_clock),
    .o_chip_select_n(chip_select_n), .o_clear_oe(clear_oe),
    .o_program_select(program_select), .o_data_wire(data_wire)
  );
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  initial begin
    i_clock = 1'h0;
    forever #25 i_clock = ~i_clock;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #2;
  endtask
  task automatic check(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // the gate array takes each bit off the wire, so the wire is compared
  task automatic read(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      check("data", PAT[i], data_wire);
      check("data_oe", 1'h1, mem_data_oe);
      if (i < hi)
        gm_u.pulse();
    end
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == CYC_MAX) begin
      num_errors++;
      results();
    end
  end
  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    i_arst_n = 1'h0;
    tick(8);
    check("data_oe", 1'h0, mem_data_oe);
    check("chain", 1'h1, chain_enable_out_n);
    check("standby", 1'h0, standby);
    check("polarity", 1'h1, clear_polarity_high);
    i_arst_n = 1'h1;
    tick(4);
    gm_u.set_pins(1'h1, 1'h0, 1'h0);
    tick(4);
    for (int i = 0; i < 16; i++) begin
      gm_u.set_data(1'h1, PAT[i]);
      gm_u.pulse();
      check("data_oe", 1'h0, mem_data_oe);
    end
    gm_u.set_data(1'h0, 1'h0);
    foreach (ROWS[r]) begin
      gm_u.set_pins(ROWS[r][4], ROWS[r][3], ROWS[r][2]);
      tick(10);
      check("standby", ROWS[r][1], standby);
      check("data_oe", ROWS[r][0], mem_data_oe);
    end
    // deselect in mid-stream: the edge is ignored and no bit is lost
    read(0, 2);
    gm_u.set_pins(1'h1, 1'h0, 1'h1);
    tick(4);
    gm_u.pulse();
    gm_u.set_pins(1'h0, 1'h0, 1'h1);
    tick(8);
    read(2, 15);
    gm_u.pulse();
    check("data_oe", 1'h0, mem_data_oe);
    check("chain", 1'h0, chain_enable_out_n);
    gm_u.set_pins(1'h1, 1'h0, 1'h1);
    tick(4);
    check("chain", 1'h1, chain_enable_out_n);
    gm_u.set_pins(1'h0, 1'h0, 1'h1);
    tick(4);
    check("chain", 1'h0, chain_enable_out_n);
    // clear held at ground: the counters stay spent, so data stays off
    check("data_oe", 1'h0, mem_data_oe);
    gm_u.set_pins(1'h0, 1'h1, 1'h1);
    tick(4);
    check("chain", 1'h1, chain_enable_out_n);
    // clear in mid-stream restarts at address zero
    gm_u.set_pins(1'h0, 1'h0, 1'h1);
    tick(8);
    read(0, 4);
    gm_u.set_pins(1'h0, 1'h1, 1'h1);
    tick(4);
    check("data_oe", 1'h0, mem_data_oe);
    gm_u.set_pins(1'h0, 1'h0, 1'h1);
    tick(8);
    read(0, 1);
    // store the low-level polarity, then the low level clears
    gm_u.set_pins(1'h1, 1'h1, 1'h0);
    tick(4);
    gm_u.set_data(1'h1, 1'h0);
    gm_u.pulse();
    gm_u.set_data(1'h0, 1'h0);
    check("polarity", 1'h0, clear_polarity_high);
    gm_u.set_pins(1'h0, 1'h1, 1'h1);
    tick(8);
    read(0, 3);
    gm_u.set_pins(1'h0, 1'h0, 1'h1);
    tick(4);
    check("data_oe", 1'h0, mem_data_oe);
    gm_u.set_pins(1'h0, 1'h1, 1'h1);
    tick(8);
    read(0, 0);
    // reset in mid-run: outputs return to reset values, contents survive
    i_arst_n = 1'h0;
    tick(2);
    check("data_oe", 1'h0, mem_data_oe);
    check("chain", 1'h1, chain_enable_out_n);
    check("polarity", 1'h1, clear_polarity_high);
    check("standby", 1'h0, standby);
    i_arst_n = 1'h1;
    gm_u.set_pins(1'h0, 1'h0, 1'h1);
    tick(8);
    read(0, 1);
    results();
  end
endmodule
